// ### inc/phe_pkg.sv
// package: constants, register map and states of the push and hold entry logic
package phe_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int WAKE_NS = 50_000;
    localparam int WAKE_CYCLES = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFF_CTRL = 6'h00;
    localparam logic [5:0] OFF_TARGET = 6'h04;
    localparam logic [5:0] OFF_BAND = 6'h08;
    localparam logic [5:0] OFF_ZONE_HI = 6'h0C;
    localparam logic [5:0] OFF_ZONE_LO = 6'h10;
    localparam logic [5:0] OFF_MODE = 6'h14;
    localparam logic [5:0] OFF_PUSH_SPEED = 6'h18;
    localparam logic [5:0] OFF_JUDGE_MS = 6'h1C;
    localparam logic [5:0] OFF_DELAY1 = 6'h20;
    localparam logic [5:0] OFF_DELAY2 = 6'h24;
    localparam logic [5:0] OFF_DELAY3 = 6'h28;
    localparam logic [5:0] OFF_STATUS = 6'h2C;
    localparam logic [5:0] OFF_IRQ_STAT = 6'h30;
    localparam logic [5:0] OFF_IRQ_MASK = 6'h34;
    localparam logic [5:0] OFF_POSITION = 6'h38;

    // ****************************************
    // fields
    // ****************************************
    localparam int CTRL_START_BIT = 0;
    localparam int MODE_PUSH_LSB = 0;
    localparam int MODE_INCR_BIT = 8;
    localparam int MODE_STAND_LSB = 9;
    localparam int MODE_ACC_BIT = 12;
    localparam int MODE_CMD_BIT = 13;
    localparam int MODE_W = 14;
    localparam logic [7:0] PUSH_MIN_PCT = 8'h14;
    localparam logic [15:0] PUSH_SPEED_MAX = 16'h07D0;
    localparam logic [15:0] PUSH_SPEED_RST = 16'h03E8;
    localparam logic [15:0] JUDGE_MS_RST = 16'h0064;
    localparam logic [15:0] DELAY_RST = 16'h03E8;
    localparam logic [2:0] STAND_OFF = 3'h0;
    localparam logic [2:0] STAND_AUTO3 = 3'h3;
    localparam logic [2:0] STAND_FULL = 3'h4;

    // ****************************************
    // events, one sticky status bit each
    // ****************************************
    localparam int EV_DONE = 0;
    localparam int EV_MISS = 1;
    localparam int EV_SERVO_ERR = 2;
    localparam int EV_PUSHBACK = 3;
    localparam int EV_LOW_PUSH = 4;
    localparam int N_EV = 5;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAKE,
        ST_MOVE,
        ST_PUSH,
        ST_HOLD,
        ST_MISSED,
        ST_DONE,
        ST_FAULT
    } phe_state_t;

endpackage : phe_pkg

// ### core/phe_entry.sv
// module: sequencing of one position table entry, plain or push and hold move
//
// Function
// - band limits push distance beyond target
// - zone output follows entry zone bounds
// - incremental flag: 0 absolute, 1 relative
// - standstill code applied after a plain (push 0) move completes
// - full servo: servo on, reduced hold
// - auto servo-off after delay, wake first
// - push 0 positions, else push percent
// - push limit never below twenty percent
// - push at parameter speed, capped 20mm/s
// - complete after limit held judgment time
// - band traversed without contact: no complete
// - load yields: follow, complete tracks limit
// - pushed back: complete stays asserted
// - pushed back to target raises alarm
// - contact before target: servo error alarm
// - band applied with its sign
// - acceleration and command modes ignored
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module phe_entry #(
    parameter int MS_CYCLES_P = phe_pkg::MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [phe_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic signed [31:0] actual_pos_i,
    input wire logic current_at_limit_i,
    output logic signed [31:0] cmd_pos_o,
    output logic [7:0] current_limit_o,
    output logic servo_on_o,
    output logic hold_reduce_o,
    output logic moving_o,
    output logic pos_complete_o,
    output logic position_zone_out_o,
    output logic alarm_o,
    output logic irq_o
);
    import phe_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic signed [31:0] target;
    logic signed [31:0] band;
    logic signed [31:0] zone_hi;
    logic signed [31:0] zone_lo;
    logic [MODE_W-1:0] mode;
    logic [15:0] push_speed;
    logic [15:0] judge_ms;
    logic [15:0] delay [3];
    logic [N_EV-1:0] irq_stat;
    logic [N_EV-1:0] irq_mask;
    logic [N_EV-1:0] ev;
    phe_state_t state;
    logic signed [31:0] tgt;
    logic signed [31:0] push_end;
    logic signed [31:0] contact_pos;
    logic [7:0] push_pct;
    logic [2:0] stand;
    logic [31:0] step_acc;
    logic step_en;
    logic [31:0] ms_cnt;
    logic ms_tick;
    logic [15:0] judge_cnt;
    logic [15:0] idle_ms;
    logic [15:0] wake_cnt;
    logic wr;
    logic rd_ok;
    logic start;
    logic [31:0] next_rd;
    logic [7:0] next_pct;
    logic [2:0] next_stand;
    logic [15:0] speed_eff;
    logic band_neg;
    logic reached;
    logic at_end;
    logic judge_hit;
    logic pushed_back;
    logic back_to_tgt;
    logic signed [31:0] pos_err;
    logic [31:0] abs_err;
    logic [31:0] abs_band;

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign rd_ok = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign start = wr && wb_adr_i == OFF_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START_BIT]
        && state != ST_WAKE && state != ST_MOVE && state != ST_PUSH;

    // ****************************************
    // wishbone slave, one wait cycle
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= rd_ok;
            wb_dat_o <= next_rd;
        end
    end

    // unmapped offsets read zero and still get an ack
    always_comb
    begin
        next_rd = 32'h0000_0000;
        unique case (wb_adr_i)
            OFF_TARGET: next_rd = target;
            OFF_BAND: next_rd = band;
            OFF_ZONE_HI: next_rd = zone_hi;
            OFF_ZONE_LO: next_rd = zone_lo;
            OFF_MODE: next_rd = {18'h0_0000, mode};
            OFF_PUSH_SPEED: next_rd = {16'h0000, push_speed};
            OFF_JUDGE_MS: next_rd = {16'h0000, judge_ms};
            OFF_DELAY1: next_rd = {16'h0000, delay[0]};
            OFF_DELAY2: next_rd = {16'h0000, delay[1]};
            OFF_DELAY3: next_rd = {16'h0000, delay[2]};
            OFF_STATUS: next_rd = {21'h00_0000, push_pct, state};
            OFF_IRQ_STAT: next_rd = {27'h000_0000, irq_stat};
            OFF_IRQ_MASK: next_rd = {27'h000_0000, irq_mask};
            OFF_POSITION: next_rd = actual_pos_i;
            default: next_rd = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // entry and parameter registers
    // ****************************************
    // acceleration and command modes stored only
    // acceleration and command mode bits are stored for readback only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            target <= 32'sh0000_0000;
            band <= 32'sh0000_0000;
            zone_hi <= 32'sh0000_0000;
            zone_lo <= 32'sh0000_0000;
            mode <= 14'h0000;
            push_speed <= PUSH_SPEED_RST;
            judge_ms <= JUDGE_MS_RST;
            irq_mask <= 5'h00;
            delay[0] <= DELAY_RST;
            delay[1] <= DELAY_RST;
            delay[2] <= DELAY_RST;
        end
        else if (wr)
        begin
            unique case (wb_adr_i)
                OFF_TARGET: target <= wb_dat_i;
                OFF_BAND: band <= wb_dat_i;
                OFF_ZONE_HI: zone_hi <= wb_dat_i;
                OFF_ZONE_LO: zone_lo <= wb_dat_i;
                OFF_MODE: mode <= wb_dat_i[MODE_W-1:0];
                OFF_PUSH_SPEED: push_speed <= wb_dat_i[15:0];
                OFF_JUDGE_MS: judge_ms <= wb_dat_i[15:0];
                OFF_DELAY1: delay[0] <= wb_dat_i[15:0];
                OFF_DELAY2: delay[1] <= wb_dat_i[15:0];
                OFF_DELAY3: delay[2] <= wb_dat_i[15:0];
                OFF_IRQ_MASK: irq_mask <= wb_dat_i[N_EV-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // interrupts
    // ****************************************
    // a new event beats a write-one clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat <= 5'h00;
            irq_o <= 1'b0;
        end
        else
        begin
            if (wr && wb_adr_i == OFF_IRQ_STAT && wb_sel_i[0])
                irq_stat <= (irq_stat & ~wb_dat_i[N_EV-1:0]) | ev;
            else
                irq_stat <= irq_stat | ev;
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // ****************************************
    // entry decode at start
    // ****************************************
    always_comb
    begin
        next_pct = mode[MODE_PUSH_LSB +: 8];
        if (next_pct != 8'h00 && next_pct < PUSH_MIN_PCT)
            next_pct = PUSH_MIN_PCT;
        next_stand = mode[MODE_STAND_LSB +: 3];
        if (next_stand > STAND_FULL)
            next_stand = STAND_OFF;
    end

    assign speed_eff = (push_speed > PUSH_SPEED_MAX) ? PUSH_SPEED_MAX : push_speed;
    assign band_neg = band[31];
    assign pos_err = actual_pos_i - tgt;
    assign abs_err = pos_err[31] ? 32'(-pos_err) : 32'(pos_err);
    assign abs_band = band_neg ? 32'(-band) : 32'(band);
    assign reached = push_pct != 8'h00 ? pos_err == 32'sh0000_0000 : abs_err <= abs_band;
    assign at_end = cmd_pos_o == push_end && actual_pos_i == push_end;
    assign judge_hit = ms_tick && current_at_limit_i && judge_cnt + 16'h0001 >= judge_ms;
    assign pushed_back = band_neg ? actual_pos_i > contact_pos : actual_pos_i < contact_pos;
    assign back_to_tgt = band_neg ? actual_pos_i >= tgt : actual_pos_i <= tgt;

    // ****************************************
    // time bases
    // ****************************************
    // step pacing by rate accumulator: speed in 0.01 mm/s, one step is 0.01 mm
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (state != ST_PUSH && state != ST_HOLD))
        begin
            step_acc <= 32'h0000_0000;
            step_en <= 1'b0;
        end
        else if (step_acc + {16'h0000, speed_eff} >= 32'(CLK_HZ))
        begin
            step_acc <= step_acc + {16'h0000, speed_eff} - 32'(CLK_HZ);
            step_en <= 1'b1;
        end
        else
        begin
            step_acc <= step_acc + {16'h0000, speed_eff};
            step_en <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || ms_cnt == 32'(MS_CYCLES_P - 1))
            ms_cnt <= 32'h0000_0000;
        else
            ms_cnt <= ms_cnt + 32'h0000_0001;
        ms_tick <= !rst_i && ms_cnt == 32'(MS_CYCLES_P - 1);
    end

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
            tgt <= 32'sh0000_0000;
            push_end <= 32'sh0000_0000;
            contact_pos <= 32'sh0000_0000;
            push_pct <= 8'h00;
            stand <= STAND_OFF;
            cmd_pos_o <= 32'sh0000_0000;
            judge_cnt <= 16'h0000;
            wake_cnt <= 16'h0000;
            pos_complete_o <= 1'b0;
            alarm_o <= 1'b0;
            ev <= 5'h00;
        end
        else
        begin
            ev <= 5'h00;
            unique case (state)
                ST_IDLE, ST_HOLD, ST_MISSED, ST_DONE, ST_FAULT:
                begin
                    if (start)
                    begin
                        tgt <= mode[MODE_INCR_BIT] ? actual_pos_i + target : target;
                        push_pct <= next_pct;
                        stand <= next_stand;
                        pos_complete_o <= 1'b0;
                        alarm_o <= 1'b0;
                        judge_cnt <= 16'h0000;
                        wake_cnt <= 16'h0000;
                        ev[EV_LOW_PUSH] <= next_pct != mode[MODE_PUSH_LSB +: 8];
                        state <= servo_on_o ? ST_MOVE : ST_WAKE;
                    end
                    else if (state == ST_HOLD)
                    begin
                        if (back_to_tgt)
                        begin
                            alarm_o <= 1'b1;
                            pos_complete_o <= 1'b0;
                            ev[EV_PUSHBACK] <= 1'b1;
                            state <= ST_FAULT;
                        end
                        else
                        begin
                            if (step_en && !current_at_limit_i && cmd_pos_o != push_end)
                                cmd_pos_o <= band_neg ? cmd_pos_o - 32'sh0000_0001
                                                      : cmd_pos_o + 32'sh0000_0001;
                            pos_complete_o <= current_at_limit_i || pushed_back;
                        end
                    end
                end
                ST_WAKE:
                begin
                    if (wake_cnt == 16'(WAKE_CYCLES - 1))
                        state <= ST_MOVE;
                    else
                        wake_cnt <= wake_cnt + 16'h0001;
                end
                ST_MOVE:
                begin
                    cmd_pos_o <= tgt;
                    if (push_pct != 8'h00 && current_at_limit_i && !reached)
                    begin
                        alarm_o <= 1'b1;
                        ev[EV_SERVO_ERR] <= 1'b1;
                        state <= ST_FAULT;
                    end
                    else if (reached && push_pct == 8'h00)
                    begin
                        pos_complete_o <= 1'b1;
                        ev[EV_DONE] <= 1'b1;
                        state <= ST_DONE;
                    end
                    else if (reached)
                    begin
                        // band as push distance past target
                        push_end <= tgt + band;
                        state <= ST_PUSH;
                    end
                end
                ST_PUSH:
                begin
                    if (step_en && cmd_pos_o != push_end)
                        cmd_pos_o <= band_neg ? cmd_pos_o - 32'sh0000_0001
                                              : cmd_pos_o + 32'sh0000_0001;
                    if (ms_tick)
                        judge_cnt <= current_at_limit_i ? judge_cnt + 16'h0001 : 16'h0000;
                    if (judge_hit)
                    begin
                        pos_complete_o <= 1'b1;
                        contact_pos <= actual_pos_i;
                        ev[EV_DONE] <= 1'b1;
                        state <= ST_HOLD;
                    end
                    else if (at_end)
                    begin
                        ev[EV_MISS] <= 1'b1;
                        state <= ST_MISSED;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // standstill and drive outputs
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            servo_on_o <= 1'b1;
            hold_reduce_o <= 1'b0;
            idle_ms <= 16'h0000;
            moving_o <= 1'b0;
            current_limit_o <= 8'h00;
            position_zone_out_o <= 1'b0;
        end
        else
        begin
            moving_o <= state == ST_MOVE || state == ST_PUSH;
            current_limit_o <= push_pct;
            position_zone_out_o <= actual_pos_i >= zone_lo && actual_pos_i <= zone_hi;
            if (state == ST_WAKE)
            begin
                servo_on_o <= 1'b1;
                hold_reduce_o <= 1'b0;
                idle_ms <= 16'h0000;
            end
            else if (state == ST_FAULT)
            begin
                servo_on_o <= 1'b0;
                hold_reduce_o <= 1'b0;
            end
            else if (state == ST_DONE)
            begin
                hold_reduce_o <= stand == STAND_FULL;
                if (stand != STAND_OFF && stand <= STAND_AUTO3 && ms_tick)
                begin
                    if (idle_ms + 16'h0001 >= delay[2'(stand - 3'h1)])
                        servo_on_o <= 1'b0;
                    else
                        idle_ms <= idle_ms + 16'h0001;
                end
            end
            else
            begin
                hold_reduce_o <= 1'b0;
                idle_ms <= 16'h0000;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_contact_early;
        state == ST_MOVE && push_pct != 8'h00 && current_at_limit_i && !reached;
    endsequence
    sequence s_fault_up;
        state == ST_FAULT && alarm_o ##1 !servo_on_o;
    endsequence
    sequence s_wake_start;
        start && !servo_on_o;
    endsequence

    a_low_push_floor: assert property (
        start && next_pct != 8'h00 |=> push_pct >= PUSH_MIN_PCT)
        else $error("push limit below floor");
    a_incr_target: assert property (
        start && mode[MODE_INCR_BIT] |=> tgt == $past(actual_pos_i) + $past(target))
        else $error("relative target wrong");
    a_zone_follow: assert property (
        actual_pos_i >= zone_lo && actual_pos_i <= zone_hi |=> position_zone_out_o)
        else $error("zone output missing");
    a_early_contact: assert property (
        s_contact_early |=> s_fault_up)
        else $error("no servo error on early contact");
    a_pushback_alarm: assert property (
        state == ST_HOLD && !start && back_to_tgt |=> alarm_o && state == ST_FAULT)
        else $error("pushback alarm missing");
    a_miss_no_complete: assert property (
        state == ST_PUSH && !judge_hit && at_end |=> state == ST_MISSED && !pos_complete_o)
        else $error("complete raised on missed load");
    a_full_servo_hold: assert property (
        state == ST_DONE && stand == STAND_FULL ##1 state == ST_DONE |=> servo_on_o
        && hold_reduce_o)
        else $error("full servo standstill wrong");
    a_wake_before_move: assert property (
        s_wake_start |=> state == ST_WAKE ##1 servo_on_o)
        else $error("move began with servo off");
    a_push_judge: assert property (
        state == ST_PUSH && judge_hit |=> state == ST_HOLD && pos_complete_o)
        else $error("push completion not declared");
    a_band_end: assert property (
        state == ST_MOVE && push_pct != 8'h00 && reached && !current_at_limit_i
        |=> push_end == $past(tgt) + $past(band))
        else $error("push end not target plus band");

endmodule : phe_entry

`default_nettype wire

// ### testbench/phe_plant.sv
// partner model: actuator and a stiff load seen by the entry logic
`timescale 1ns/1ps
`default_nettype none
module phe_plant (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic servo_on_i,
    input wire logic signed [31:0] cmd_pos_i,
    input wire logic load_en_i,
    input wire logic signed [31:0] load_pos_i,
    output logic signed [31:0] actual_pos_o,
    output logic at_limit_o
);
    // ****
    // motion
    // ****
    // servo off: the actuator stays where it was left
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            actual_pos_o <= 32'sh0;
            at_limit_o <= 1'b0;
        end
        else
        begin
            if (servo_on_i)
                actual_pos_o <= (load_en_i && cmd_pos_i > load_pos_i) ? load_pos_i : cmd_pos_i;
            at_limit_o <= load_en_i && (cmd_pos_i >= load_pos_i);
        end
    end
endmodule : phe_plant
`default_nettype wire

// ### testbench/tb_phe_entry.sv
// testbench: registers, plain moves, standstill, push and hold
`timescale 1ns/1ps
`default_nettype none
module tb_phe_entry;
    import phe_pkg::*;
    typedef struct {logic [13:0] mode; int tgt, zhi, zlo, pos; logic zone, hold;} phe_row_t;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, load_en = 0, at_lim, ack;
    logic srv, hold, mov, cmpl, zone, alarm, irq;
    logic [5:0] adr = '0;
    logic [7:0] lim;
    logic [31:0] wdat = '0, rdat, q;
    logic signed [31:0] act, cmd, load_pos = 32'sh0;
    int error_cnt = 0, checks_done = 0, ticks = 0;
    phe_row_t rows [3] = '{'{14'h0000, 50, 100, 0, 50, 1, 0}, '{14'h0900, -20, 20, 0, 30, 0, 1},
        '{14'h3A00, 40, 45, 40, 40, 1, 0}};
    phe_entry #(.MS_CYCLES_P(20)) phe_entry_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .actual_pos_i(act), .current_at_limit_i(at_lim),
        .cmd_pos_o(cmd), .current_limit_o(lim), .servo_on_o(srv), .hold_reduce_o(hold),
        .moving_o(mov), .pos_complete_o(cmpl), .position_zone_out_o(zone), .alarm_o(alarm),
        .irq_o(irq));
    phe_plant phe_plant_inst (.clk_i(clk_i), .rst_i(rst_i), .servo_on_i(srv), .cmd_pos_i(cmd),
        .load_en_i(load_en), .load_pos_i(load_pos), .actual_pos_o(act), .at_limit_o(at_lim));
    // ****
    // tasks
    // ****
    always #12.5 clk_i = ~clk_i;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    // long pushes dominate the run time
    always @(posedge clk_i)
    begin
        ticks++;
        if (ticks == 90000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // no local limit: only the cycle ceiling ends a wait for ack
        do
            @(posedge clk_i);
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic go(input logic [13:0] m, input int t, input int b);
        bus(1, OFF_MODE, {18'h0, m});
        bus(1, OFF_TARGET, t);
        bus(1, OFF_BAND, b);
        bus(1, OFF_CTRL, 32'h1);
        repeat (3) @(posedge clk_i);
    endtask : go
    task automatic wt(input logic alm, input int lim);
        int n;
        n = 0;
        while ((alm ? alarm : cmpl) !== 1'b1 && n < lim)
        begin
            @(posedge clk_i);
            n++;
        end
        if ((alm ? alarm : cmpl) !== 1'b1)
        begin
            error_cnt++;
            $display("mismatch wait expected 1 seen %b", alm ? alarm : cmpl);
        end
        repeat (4) @(posedge clk_i);
    endtask : wt
    // ****
    // main sequence
    // ****
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("servo_rst", 1, srv);
        bus(0, OFF_PUSH_SPEED, 0);
        chk("speed_rst", 32'h3E8, q);
        bus(0, 6'h3C, 0);
        chk("unmapped", 0, q);
        $display("test registers done");
        bus(1, OFF_JUDGE_MS, 2);
        bus(1, OFF_DELAY1, 1);
        // above the cap on purpose, so the push pacing shows the clamp
        bus(1, OFF_PUSH_SPEED, 32'h0000_FFFF);
        foreach (rows[i])
        begin
            bus(1, OFF_ZONE_HI, rows[i].zhi);
            bus(1, OFF_ZONE_LO, rows[i].zlo);
            go(rows[i].mode, rows[i].tgt, 2);
            wt(0, 200);
            chk("complete", 1, cmpl);
            chk("cmd_pos", rows[i].pos, cmd);
            chk("zone", rows[i].zone, zone);
            chk("hold", rows[i].hold, hold);
            chk("servo", 1, srv);
            $display("test row %0d done", i);
        end
        go(14'h0200, 60, 2);
        wt(0, 200);
        repeat (45) @(posedge clk_i);
        chk("servo_off", 0, srv);
        go(14'h0000, 70, 2);
        chk("wake_servo", 1, srv);
        chk("wake_still", 0, mov);
        wt(0, 2200);
        chk("wake_pos", 70, cmd);
        $display("test standstill done");
        bus(1, OFF_IRQ_MASK, 1);
        bus(1, OFF_IRQ_STAT, 32'h0000_001F);
        load_pos <= 102;
        load_en <= 1'b1;
        go(14'h000A, 100, 4);
        chk("moving", 1, mov);
        chk("irq_masked", 0, irq);
        repeat (10000) @(posedge clk_i);
        chk("push_speed", 100, cmd);
        wt(0, 35000);
        chk("push_done", 1, cmpl);
        chk("floor", 20, lim);
        chk("contact", 102, cmd);
        chk("irq_on", 1, irq);
        bus(0, OFF_IRQ_STAT, 0);
        chk("irq_stat", 32'h11, q);
        bus(1, OFF_IRQ_STAT, 32'h11);
        repeat (3) @(posedge clk_i);
        chk("irq_off", 0, irq);
        load_pos <= 103;
        repeat (4) @(posedge clk_i);
        chk("yield", 0, cmpl);
        load_pos <= 102;
        repeat (4) @(posedge clk_i);
        chk("relimit", 1, cmpl);
        load_pos <= 101;
        repeat (4) @(posedge clk_i);
        chk("pushed", 1, cmpl);
        load_pos <= 100;
        wt(1, 10);
        chk("pushback", 1, alarm);
        $display("test push done");
        load_en <= 1'b0;
        go(14'h0014, 200, -1);
        repeat (24000) @(posedge clk_i);
        chk("missed", 0, cmpl);
        chk("band_sign", 199, cmd);
        bus(0, OFF_STATUS, 0);
        chk("state", 5, {29'h0, q[2:0]});
        load_pos <= 250;
        load_en <= 1'b1;
        go(14'h0014, 300, 2);
        wt(1, 2300);
        chk("early", 1, alarm);
        chk("early_cmpl", 0, cmpl);
        $display("test faults done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("rst_alarm", 0, alarm);
        chk("rst_servo", 1, srv);
        bus(0, OFF_JUDGE_MS, 0);
        chk("judge_rst", JUDGE_MS_RST, q);
        $display("test reset done");
        complete_run();
    end
endmodule : tb_phe_entry
`default_nettype wire
